// ---- verilog/eipc_pkg.sv ----
// Constants for the external pin interrupt edge and priority controller
package eipc_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          REG_W         = 8;
  localparam int          N_PIN         = 4;
  localparam int          N_SRC         = 6;
  // Source index in the per-source vectors
  localparam int          SRC_PIN0      = 0;
  localparam int          SRC_PIN1      = 1;
  localparam int          SRC_PIN2      = 2;
  localparam int          SRC_PIN3      = 3;
  localparam int          SRC_TIMER_ZERO      = 4;
  localparam int          SRC_PORTB     = 5;
  // Register byte offsets
  localparam logic [7:0]  OFS_EDGE_CFG  = 8'h00;
  localparam logic [7:0]  OFS_PIN_CTRL  = 8'h04;
  localparam logic [7:0]  OFS_CORE_CTRL = 8'h08;
  localparam logic [7:0]  OFS_SRC_FLAGS = 8'h0c;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h10;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h14;
  // Reset values
  localparam logic [3:0]  RST_EDGE_SEL  = 4'hf;
  localparam logic [5:0]  RST_PRIO      = 6'h3f;
  localparam logic [5:0]  RST_PRIO_PIN  = 6'h07;
  localparam logic [5:0]  RST_EN        = 6'h00;
  localparam logic        RST_PULLUP    = 1'h1;
  // external_edge_and_priority_config fields
  localparam int          B_PULLUP      = 7;
  localparam int          B_EDGE_PIN0   = 6;
  localparam int          B_TIMER_ZERO_PRIO   = 2;
  localparam int          B_PIN3_PRIO   = 1;
  localparam int          B_PORTB_PRIO  = 0;
  // external_pin_irq_control fields
  localparam int          B_PIN2_PRIO   = 7;
  localparam int          B_PIN1_PRIO   = 6;
  localparam int          B_EN_PIN1     = 3;
  localparam int          B_FLAG_PIN1   = 0;
  // Core control fields
  localparam int          B_GLOBAL_HIGH_IRQ_ENABLE        = 0;
  localparam int          B_GLOBAL_LOW_IRQ_ENABLE        = 1;
  localparam int          B_PMODE       = 2;
  localparam int          B_EN_PIN0     = 3;
  localparam int          B_EN_TIMER_ZERO     = 4;
  localparam int          B_EN_PORTB    = 5;
  // Core flag fields
  localparam int          B_FLAG_PIN0   = 0;
  localparam int          B_FLAG_TIMER_ZERO   = 1;
  localparam int          B_FLAG_PORTB  = 2;
endpackage

// ---- verilog/eipc_ctrl.sv ----
// External pin interrupt edge, priority, enable and flag controller
// Contract
// RULE_01: Flags set regardless of any enable bit
// RULE_02: Software clears flag before enabling source
// RULE_03: Per-pin edge select, one rising, resets one
// RULE_04: Priority bits pick high or low request
// RULE_05: Pin enables gate requests, reset to zero
// RULE_06: Pin flag set on edge, software clears
// RULE_07: Mode bit splits global enable high/low
// RULE_08: Sample pins, flag one clock after edge; the flag here rises two clocks after the pin edge
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module eipc_ctrl
  import eipc_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic [N_PIN-1:0]  ext_pin,
  input  wire logic              timer_zero_overflow,
  input  wire logic              port_b_change,
  output logic                   irq_high,
  output logic                   irq_low,
  output logic                   irq,
  output logic                   port_b_pullup_disable_n
);

  logic [N_PIN-1:0] pin_q;
  logic [N_PIN-1:0] pin_prev;
  logic [N_PIN-1:0] edge_sel;
  logic [N_SRC-1:0] prio;
  logic [N_SRC-1:0] en;
  logic [N_SRC-1:0] flag;
  logic [N_SRC-1:0] status;
  logic [N_SRC-1:0] mask;
  logic             global_high_irq_enable;
  logic             global_low_irq_enable;
  logic             pmode;

  logic [N_PIN-1:0]  next_edge_sel;
  logic [N_SRC-1:0]  next_prio;
  logic [N_SRC-1:0]  next_en;
  logic [N_SRC-1:0]  next_flag;
  logic [N_SRC-1:0]  next_status;
  logic [N_SRC-1:0]  next_mask;
  logic              next_global_high_irq_enable;
  logic              next_global_low_irq_enable;
  logic              next_pmode;
  logic              next_pullup;
  logic              next_irq_high;
  logic              next_irq_low;
  logic              next_irq;
  logic              next_wait;
  logic [DATA_W-1:0] next_rdata;
  logic [N_SRC-1:0]  set_evt;
  logic [N_SRC-1:0]  pend;
  logic              wr_take;
  logic              rd_take;
  logic [REG_W-1:0]  wd;

  // Selected edge seen between two consecutive samples
  function automatic logic edge_hit(input logic sel, input logic cur,
                                    input logic prev);
    edge_hit = sel ? (cur & ~prev) : (~cur & prev);
  endfunction

  // Register read view
  function automatic logic [REG_W-1:0] reg_view(input logic [7:0] a);
    reg_view = '0;
    case (a)
      OFS_EDGE_CFG:
      begin
        reg_view[B_PULLUP] = port_b_pullup_disable_n;
        for (int i = 0; i < N_PIN; i++)
          reg_view[B_EDGE_PIN0-i] = edge_sel[i];
        reg_view[B_TIMER_ZERO_PRIO]  = prio[SRC_TIMER_ZERO];
        reg_view[B_PIN3_PRIO]  = prio[SRC_PIN3];
        reg_view[B_PORTB_PRIO] = prio[SRC_PORTB];
      end
      OFS_PIN_CTRL:
      begin
        reg_view[B_PIN2_PRIO] = prio[SRC_PIN2];
        reg_view[B_PIN1_PRIO] = prio[SRC_PIN1];
        for (int i = 0; i < 3; i++)
        begin
          reg_view[B_EN_PIN1+i]   = en[SRC_PIN1+i];
          reg_view[B_FLAG_PIN1+i] = flag[SRC_PIN1+i];
        end
      end
      OFS_CORE_CTRL:
      begin
        reg_view[B_GLOBAL_HIGH_IRQ_ENABLE]     = global_high_irq_enable;
        reg_view[B_GLOBAL_LOW_IRQ_ENABLE]     = global_low_irq_enable;
        reg_view[B_PMODE]    = pmode;
        reg_view[B_EN_PIN0]  = en[SRC_PIN0];
        reg_view[B_EN_TIMER_ZERO]  = en[SRC_TIMER_ZERO];
        reg_view[B_EN_PORTB] = en[SRC_PORTB];
      end
      OFS_SRC_FLAGS:
      begin
        reg_view[B_FLAG_PIN0]  = flag[SRC_PIN0];
        reg_view[B_FLAG_TIMER_ZERO]  = flag[SRC_TIMER_ZERO];
        reg_view[B_FLAG_PORTB] = flag[SRC_PORTB];
      end
      OFS_IRQ_STAT: reg_view[N_SRC-1:0] = status;
      OFS_IRQ_MASK: reg_view[N_SRC-1:0] = mask;
      default:      reg_view = '0;
    endcase
  endfunction

  // One wait cycle per access; waitrequest low marks the taking edge
  always_comb
  begin
    wr_take = avs_write & ~avs_waitrequest;
    rd_take = avs_read & ~avs_waitrequest;
    wd      = avs_writedata[REG_W-1:0];
    next_wait  = ~((avs_read | avs_write) & avs_waitrequest);
    next_rdata = avs_readdata;
    if (avs_read && avs_waitrequest)
      next_rdata = {{(DATA_W-REG_W){1'b0}}, reg_view(avs_address)};
  end

  always_comb
  begin
    for (int i = 0; i < N_PIN; i++)
      set_evt[i] = edge_hit(edge_sel[i], pin_q[i], pin_prev[i]); // RULE_08
    set_evt[SRC_TIMER_ZERO]  = timer_zero_overflow;
    set_evt[SRC_PORTB] = port_b_change;

    next_edge_sel = edge_sel;
    next_prio     = prio;
    next_en       = en;
    next_flag     = flag;
    next_mask     = mask;
    next_global_high_irq_enable     = global_high_irq_enable;
    next_global_low_irq_enable     = global_low_irq_enable;
    next_pmode    = pmode;
    next_pullup   = port_b_pullup_disable_n;
    if (wr_take)
    begin
      case (avs_address)
        OFS_EDGE_CFG:
        begin
          next_pullup = wd[B_PULLUP];
          for (int i = 0; i < N_PIN; i++)
            next_edge_sel[i] = wd[B_EDGE_PIN0-i]; // RULE_03
          next_prio[SRC_TIMER_ZERO]  = wd[B_TIMER_ZERO_PRIO]; // RULE_04
          next_prio[SRC_PIN3]  = wd[B_PIN3_PRIO];
          next_prio[SRC_PORTB] = wd[B_PORTB_PRIO];
        end
        OFS_PIN_CTRL:
        begin
          next_prio[SRC_PIN2] = wd[B_PIN2_PRIO]; // RULE_04
          next_prio[SRC_PIN1] = wd[B_PIN1_PRIO];
          for (int i = 0; i < 3; i++)
          begin
            next_en[SRC_PIN1+i]   = wd[B_EN_PIN1+i]; // RULE_05
            next_flag[SRC_PIN1+i] = wd[B_FLAG_PIN1+i]; // RULE_06
          end
        end
        OFS_CORE_CTRL:
        begin
          next_global_high_irq_enable            = wd[B_GLOBAL_HIGH_IRQ_ENABLE];
          next_global_low_irq_enable            = wd[B_GLOBAL_LOW_IRQ_ENABLE];
          next_pmode           = wd[B_PMODE];
          next_en[SRC_PIN0]    = wd[B_EN_PIN0];
          next_en[SRC_TIMER_ZERO]    = wd[B_EN_TIMER_ZERO];
          next_en[SRC_PORTB]   = wd[B_EN_PORTB];
        end
        OFS_SRC_FLAGS:
        begin
          next_flag[SRC_PIN0]  = wd[B_FLAG_PIN0];
          next_flag[SRC_TIMER_ZERO]  = wd[B_FLAG_TIMER_ZERO];
          next_flag[SRC_PORTB] = wd[B_FLAG_PORTB];
        end
        OFS_IRQ_MASK: next_mask = wd[N_SRC-1:0];
        default:      next_mask = mask;
      endcase
    end
    // Set beats a same-cycle software clear; enables play no part
    next_flag = next_flag | set_evt; // RULE_01 RULE_06

    // Clear only the bits handed out, so a late event survives the read
    next_status = status;
    if (rd_take && avs_address == OFS_IRQ_STAT)
      next_status = status & ~avs_readdata[N_SRC-1:0];
    next_status = next_status | set_evt;

    pend          = flag & en; // RULE_05
    next_irq_high = 1'b0;
    next_irq_low  = 1'b0;
    if (!pmode)
      next_irq_high = global_high_irq_enable & (|pend); // RULE_07
    else
    begin
      next_irq_high = global_high_irq_enable & (|(pend & prio)); // RULE_04 RULE_07
      next_irq_low  = global_low_irq_enable & (|(pend & ~prio));
    end
    next_irq = |(status & mask);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      pin_q                   <= '0;
      pin_prev                <= '0;
      edge_sel                <= RST_EDGE_SEL; // RULE_03
      prio                    <= RST_PRIO; // RULE_04
      en                      <= RST_EN; // RULE_05
      flag                    <= '0;
      status                  <= '0;
      mask                    <= '0;
      global_high_irq_enable                    <= 1'b0;
      global_low_irq_enable                    <= 1'b0;
      pmode                   <= 1'b0;
      port_b_pullup_disable_n <= RST_PULLUP;
      irq_high                <= 1'b0;
      irq_low                 <= 1'b0;
      irq                     <= 1'b0;
      avs_waitrequest         <= 1'b1;
      avs_readdata            <= '0;
    end
    else
    begin
      pin_q                   <= ext_pin; // RULE_08
      pin_prev                <= pin_q;
      edge_sel                <= next_edge_sel;
      // Pin 0 has no priority bit and always requests high
      prio                    <= next_prio | (N_SRC'(1) << SRC_PIN0);
      en                      <= next_en;
      flag                    <= next_flag;
      status                  <= next_status;
      mask                    <= next_mask;
      global_high_irq_enable                    <= next_global_high_irq_enable;
      global_low_irq_enable                    <= next_global_low_irq_enable;
      pmode                   <= next_pmode;
      port_b_pullup_disable_n <= next_pullup;
      irq_high                <= next_irq_high;
      irq_low                 <= next_irq_low;
      irq                     <= next_irq;
      avs_waitrequest         <= next_wait;
      avs_readdata            <= next_rdata;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_flag_set_any_enable;
    (|set_evt) |=> ((flag & $past(set_evt)) == $past(set_evt));
  endproperty
  a_flag_set_any_enable: assert property (p_flag_set_any_enable) // RULE_01
    else $error("flag missed its event");

  property p_rise_edge_pin0;
    (edge_sel[SRC_PIN0] && !pin_prev[SRC_PIN0] && pin_q[SRC_PIN0])
      |=> flag[SRC_PIN0];
  endproperty
  a_rise_edge_pin0: assert property (p_rise_edge_pin0) // RULE_03
    else $error("rising edge on pin 0 not flagged");

  property p_fall_ignored_pin1;
    (edge_sel[SRC_PIN1] && pin_prev[SRC_PIN1] && !pin_q[SRC_PIN1]
      && !flag[SRC_PIN1] && !avs_write) |=> !flag[SRC_PIN1];
  endproperty
  a_fall_ignored_pin1: assert property (p_fall_ignored_pin1) // RULE_03
    else $error("falling edge flagged while rising selected");

  property p_pin_to_flag;
    $rose(ext_pin[SRC_PIN2]) && edge_sel[SRC_PIN2]
      |-> ##2 flag[SRC_PIN2];
  endproperty
  a_pin_to_flag: assert property (p_pin_to_flag) // RULE_08
    else $error("pin edge did not flag two cycles later");

  property p_flag_holds;
    flag[SRC_PIN3] && !avs_write |=> flag[SRC_PIN3];
  endproperty
  a_flag_holds: assert property (p_flag_holds) // RULE_06
    else $error("pin flag cleared without a write");

  property p_masked_quiet;
    !(|(flag & en)) |=> !irq_high && !irq_low;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) // RULE_05
    else $error("request raised with nothing enabled");

  property p_high_prio_request;
    pmode && global_high_irq_enable && (|(flag & en & prio)) |=> irq_high;
  endproperty
  a_high_prio_request: assert property (p_high_prio_request) // RULE_04
    else $error("high priority request missing");

  property p_low_gated;
    (!pmode || !global_low_irq_enable) |=> !irq_low;
  endproperty
  a_low_gated: assert property (p_low_gated) // RULE_07
    else $error("low request without its enable");

endmodule
`default_nettype wire

// ---- bench/eipc_pin_model.sv ----
// Behavioural model of the pins and event sources facing the controller
`timescale 1ns/1ps
`default_nettype none
module eipc_pin_model
(
  input  wire logic       clk_sys,
  input  wire logic [3:0] pin_req,
  input  wire logic       tmr_req,
  input  wire logic       pb_req,
  output logic      [3:0] ext_pin,
  output logic            timer_zero_overflow,
  output logic            port_b_change
);
  initial
  begin
    ext_pin = 4'h0;
    timer_zero_overflow = 1'h0;
    port_b_change = 1'h0;
  end
  // Pads move only just after an edge, never mid-cycle
  always @(posedge clk_sys)
  begin
    ext_pin <= pin_req;
    timer_zero_overflow <= tmr_req;
    port_b_change <= pb_req;
  end
endmodule
`default_nettype wire

// ---- bench/eipc_ctrl_tb_top.sv ----
// Self-checking bench for the pin interrupt controller
`timescale 1ns/1ps
`default_nettype none
module eipc_ctrl_tb_top import eipc_pkg::*;;
  logic              clk_sys = 1'h0;
  logic              resetn = 1'h0;
  logic [ADDR_W-1:0] avs_address = 8'h0;
  logic              avs_read = 1'h0;
  logic              avs_write = 1'h0;
  logic [DATA_W-1:0] avs_writedata = 32'h0;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              irq_high;
  logic              irq_low;
  logic              irq;
  logic              pullup_n;
  logic [N_PIN-1:0]  ext_pin;
  logic [N_PIN-1:0]  pin_req = 4'h0;
  logic              tmr_zo;
  logic              pb_chg;
  logic              tmr_req = 1'h0;
  logic              pb_req = 1'h0;
  int                error_cnt = 0;
  int                check_count = 0;
  int                cyc = 0;
  logic [31:0]       seed = 32'h63;
  logic [31:0]       rd;
  logic [3:0]        sel;
  logic [3:0]        prv;
  logic [3:0]        np;
  logic [3:0]        expf;
  logic [3:0]        got;
  logic [23:0]       tab [6] = '{24'h01_07_00, 24'h09_01_02, 24'h09_05_00,
                                 24'h09_06_01, 24'h49_05_02, 24'h49_06_00};

  eipc_ctrl eipc_ctrl_inst (.clk_sys(clk_sys), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_pin(ext_pin),
    .timer_zero_overflow(tmr_zo), .port_b_change(pb_chg),
    .irq_high(irq_high), .irq_low(irq_low), .irq(irq),
    .port_b_pullup_disable_n(pullup_n));
  eipc_pin_model eipc_pin_model_inst (.clk_sys(clk_sys), .pin_req(pin_req),
    .tmr_req(tmr_req), .pb_req(pb_req), .ext_pin(ext_pin),
    .timer_zero_overflow(tmr_zo), .port_b_change(pb_chg));

  always #2.5 clk_sys = ~clk_sys;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [3:0] edg(input logic [3:0] o, n, s);
    return (s & ~o & n) | (~s & o & ~n);
  endfunction

  task automatic report_and_stop();
    if (error_cnt == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    check_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, d);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'h0)
      @(posedge clk_sys);
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    // Idle edge so a following call never re-raises in this step
    @(posedge clk_sys);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 8'h0);
    chk(n, rd, e);
  endtask
  task automatic flags();
    bus(1'h0, OFS_SRC_FLAGS, 8'h0);
    got[0] = rd[0];
    bus(1'h0, OFS_PIN_CTRL, 8'h0);
    got[3:1] = rd[2:0];
  endtask
  task automatic clr();
    bus(1'h1, OFS_PIN_CTRL, 8'hc0);
    bus(1'h1, OFS_SRC_FLAGS, 8'h00);
  endtask
  task automatic pulse();
    tmr_req <= 1'h1;
    pb_req <= 1'h1;
    clks(1);
    tmr_req <= 1'h0;
    pb_req <= 1'h0;
    clks(4);
  endtask

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'h1;
    @(posedge clk_sys);
    chk("pullup", {31'h0, pullup_n}, 32'h1);
    rdc("edge_cfg", OFS_EDGE_CFG, 32'hff);
    rdc("pin_ctrl", OFS_PIN_CTRL, 32'hc0);
    rdc("unmapped", 8'h20, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      rd = xs();
      sel = (k == 0) ? 4'hf : ((k == 1) ? 4'h0 : rd[3:0]);
      bus(1'h1, OFS_EDGE_CFG, {k[0], sel[0], sel[1], sel[2], sel[3], 3'h7});
      chk("pullup", {31'h0, pullup_n}, {31'h0, k[0]});
      clks(3);
      // Flags left by the previous pass need clearing; a select change alone sets none
      clr();
      flags();
      chk("cleared", {28'h0, got}, 32'h0);
      prv = pin_req;
      expf = 4'h0;
      repeat (24)
      begin
        rd = xs();
        np = rd[7:4];
        pin_req <= np;
        clks(4);
        expf = expf | edg(prv, np, sel);
        prv = np;
      end
      flags();
      chk("flags", {28'h0, got}, {28'h0, expf});
    end
    clr();
    bus(1'h0, OFS_IRQ_STAT, 8'h0);
    bus(1'h1, OFS_IRQ_MASK, 8'h30);
    pulse();
    chk("irq", {31'h0, irq}, 32'h1);
    rdc("core_flags", OFS_SRC_FLAGS, 32'h06);
    rdc("stat", OFS_IRQ_STAT, 32'h30);
    clks(2);
    chk("irq_off", {31'h0, irq}, 32'h0);
    rdc("stat_clr", OFS_IRQ_STAT, 32'h0);
    bus(1'h1, OFS_IRQ_MASK, 8'h00);
    pulse();
    chk("irq_mask", {31'h0, irq}, 32'h0);
    rdc("stat_mask", OFS_IRQ_STAT, 32'h30);
    clr();
    for (int i = 0; i < 6; i++)
    begin
      bus(1'h1, OFS_PIN_CTRL, tab[i][23:16]);
      bus(1'h1, OFS_CORE_CTRL, tab[i][15:8]);
      clks(3);
      chk("irq_hl", {30'h0, irq_high, irq_low}, {30'h0, tab[i][1:0]});
    end
    // Pin 0 has no priority bit and must always request high
    clr();
    bus(1'h1, OFS_SRC_FLAGS, 8'h01);
    bus(1'h1, OFS_CORE_CTRL, 8'h0d);
    clks(3);
    chk("pin0_high", {30'h0, irq_high, irq_low}, 32'h2);
    report_and_stop();
  end
endmodule
`default_nettype wire
